// ---- rtl/trs_params.svh ----
// Constants for the trigger and reply signal ports block
`ifndef TRS_PARAMS_SVH
`define TRS_PARAMS_SVH
`define TRS_CLK_MHZ 40
`define TRS_MIN_TRIG_NS 100
`define TRS_MIN_TRIG_CYC ((`TRS_MIN_TRIG_NS * `TRS_CLK_MHZ + 999) / 1000)
`define TRS_WINDOW_NS 3000
`define TRS_WINDOW_CYC ((`TRS_WINDOW_NS * `TRS_CLK_MHZ) / 1000)
`define TRS_ECHO_MIN_NS 100
`define TRS_ECHO_MAX_NS 5000
`define TRS_ECHO_MIN_CYC ((`TRS_ECHO_MIN_NS * `TRS_CLK_MHZ + 999) / 1000)
`define TRS_ECHO_MAX_CYC ((`TRS_ECHO_MAX_NS * `TRS_CLK_MHZ) / 1000)
`define TRS_MAX_RATE_HZ 3000
`define TRS_CW 16
`endif

// ---- rtl/trs_pkg.sv ----
// Types for the trigger and reply signal ports block
`default_nettype none
package trs_pkg;
    typedef enum logic [1:0]
    {
        TRS_MODE_EDGE = 2'h0,
        TRS_MODE_PAIR = 2'h1,
        TRS_MODE_PASS = 2'h2
    } trs_mode_t;
    typedef enum logic [1:0]
    {
        TRS_IDLE = 2'h0,
        TRS_WAIT2 = 2'h1,
        TRS_HIGH2 = 2'h3
    } trs_state_t;
    typedef struct packed
    {
        trs_mode_t mode;
        logic dual_gen;
        logic [15:0] echo_width;
        logic [15:0] pair_space;
        logic [15:0] pair_tol;
        logic [15:0] reply_delay;
    } trs_cfg_t;
    typedef struct packed
    {
        logic amp_n;
        logic phase;
        logic amp2_n;
    } trs_reply_t;
endpackage : trs_pkg
`default_nettype wire

// ---- rtl/trs_ports.sv ----
// Trigger input qualification and reply timing outputs
`include "trs_params.svh"
`default_nettype none
module trs_ports #(
    parameter int CW = `TRS_CW
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Configuration
    input wire trs_pkg::trs_cfg_t cfg,
    // Trigger input port
    input wire logic trigger_input_port,
    // Reply sequence from the reply generators
    input wire trs_pkg::trs_reply_t reply_seq,
    // Range delay handoff
    output logic range_start,
    // Output ports
    output logic trigger_echo_port,
    output logic reply_amplitude_port,
    output logic reply_phase_port,
    output logic zero_range_marker_port
);
    localparam logic [CW-1:0] MIN_TRIG = CW'(`TRS_MIN_TRIG_CYC);
    localparam logic [CW-1:0] WIN_CYC = CW'(`TRS_WINDOW_CYC);
    localparam logic [CW-1:0] ECHO_MIN = CW'(`TRS_ECHO_MIN_CYC);
    localparam logic [CW-1:0] ECHO_MAX = CW'(`TRS_ECHO_MAX_CYC);
    localparam int WIN_LAST = `TRS_WINDOW_CYC - 1;

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        sat_inc = (v == {CW{1'b1}}) ? v : v + CW'(1);
    endfunction : sat_inc

    function automatic logic [CW-1:0] clamp_w(input logic [CW-1:0] v);
        clamp_w = (v < ECHO_MIN) ? ECHO_MIN : ((v > ECHO_MAX) ? ECHO_MAX : v);
    endfunction : clamp_w

    logic sync1, sync2, trig_d;
    logic [CW-1:0] hi_cnt, gap_cnt, echo_cnt, zr_cnt;
    logic echo, zr, pulse_ok, valid;
    trs_pkg::trs_state_t state;
    logic [CW-1:0] next_hi_cnt, next_gap_cnt, next_echo_cnt, next_zr_cnt;
    logic next_echo, next_zr, next_pulse_ok, next_amp, next_phase, next_range;
    trs_pkg::trs_state_t next_state;

    always_comb
    begin
        next_hi_cnt = sync2 ? sat_inc(hi_cnt) : '0;
        // Pulse qualifies once it has been high for the minimum width
        next_pulse_ok = sync2 && (pulse_ok || sat_inc(hi_cnt) >= MIN_TRIG);
        next_gap_cnt = sat_inc(gap_cnt);
        next_state = state;
        valid = 1'b0;
        unique case (state)
            trs_pkg::TRS_IDLE:
            begin
                if (next_pulse_ok && !pulse_ok)
                begin
                    if (cfg.mode == trs_pkg::TRS_MODE_EDGE)
                        valid = 1'b1;
                    else if (cfg.mode == trs_pkg::TRS_MODE_PAIR)
                    begin
                        next_state = trs_pkg::TRS_WAIT2;
                        next_gap_cnt = MIN_TRIG;
                    end
                end
            end
            trs_pkg::TRS_WAIT2:
            begin
                // Pair spacing measured leading edge to leading edge
                if (sync2 && !trig_d)
                begin
                    next_state = trs_pkg::TRS_HIGH2;
                    if (gap_cnt + cfg.pair_tol < cfg.pair_space)
                        next_state = trs_pkg::TRS_IDLE;
                end
                else if (gap_cnt > cfg.pair_space + cfg.pair_tol)
                    next_state = trs_pkg::TRS_IDLE;
            end
            trs_pkg::TRS_HIGH2:
            begin
                if (next_pulse_ok && !pulse_ok)
                begin
                    valid = 1'b1;
                    next_state = trs_pkg::TRS_IDLE;
                end
                else if (!sync2)
                    next_state = trs_pkg::TRS_IDLE;
            end
            default:
                next_state = trs_pkg::TRS_IDLE;
        endcase
        if (cfg.mode == trs_pkg::TRS_MODE_PASS)
            next_state = trs_pkg::TRS_IDLE;
        // Echo pulse or pass-through window
        next_echo = echo;
        next_echo_cnt = echo_cnt;
        if (cfg.mode == trs_pkg::TRS_MODE_PASS && sync2 && !trig_d && !echo)
        begin
            next_echo = 1'b1;
            next_echo_cnt = WIN_CYC - CW'(1);
        end
        else if (valid)
        begin
            next_echo = 1'b1;
            next_echo_cnt = clamp_w(CW'(cfg.echo_width)) - CW'(1);
        end
        else if (echo && echo_cnt != '0)
            next_echo_cnt = echo_cnt - CW'(1);
        else
            next_echo = 1'b0;
        // Zero-range marker after reply delay; restarts on each valid trigger, never in pass-through mode
        next_zr = 1'b0;
        next_range = 1'b0;
        next_zr_cnt = zr_cnt;
        if (valid)
            next_zr_cnt = CW'(cfg.reply_delay) + CW'(1);
        else if (zr_cnt != '0)
        begin
            next_zr_cnt = zr_cnt - CW'(1);
            next_zr = (zr_cnt == CW'(1));
            next_range = (zr_cnt == CW'(1));
        end
        // Reply outputs
        if (cfg.mode == trs_pkg::TRS_MODE_PASS)
            next_amp = !sync2;
        else
            next_amp = reply_seq.amp_n;
        next_phase = cfg.dual_gen ? reply_seq.amp2_n : reply_seq.phase;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            trig_d <= 1'b0;
            hi_cnt <= '0;
            gap_cnt <= '0;
            pulse_ok <= 1'b0;
            state <= trs_pkg::TRS_IDLE;
            echo <= 1'b0;
            echo_cnt <= '0;
            zr <= 1'b0;
            zr_cnt <= '0;
            range_start <= 1'b0;
            reply_amplitude_port <= 1'b1;
            reply_phase_port <= 1'b1;
        end
        else
        begin
            sync1 <= trigger_input_port;
            sync2 <= sync1;
            trig_d <= sync2;
            hi_cnt <= next_hi_cnt;
            gap_cnt <= next_gap_cnt;
            pulse_ok <= next_pulse_ok;
            state <= next_state;
            echo <= next_echo;
            echo_cnt <= next_echo_cnt;
            zr <= next_zr;
            zr_cnt <= next_zr_cnt;
            range_start <= next_range;
            reply_amplitude_port <= next_amp;
            reply_phase_port <= next_phase;
        end
    end

    assign trigger_echo_port = echo;
    assign zero_range_marker_port = zr;

    echo_len_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(echo) && $stable(cfg) |-> echo [*4])
        else $error("echo pulse shorter than minimum");
    pass_window_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.mode == trs_pkg::TRS_MODE_PASS && $stable(cfg.mode) && $rose(echo) |-> ##WIN_LAST echo ##1 !echo)
        else $error("window length wrong");
    short_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        valid |-> sync2 && $past(sync2) && $past(sync2, 2) && $past(sync2, 3))
        else $error("short pulse accepted");
    edge_trig_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.mode == trs_pkg::TRS_MODE_EDGE && state == trs_pkg::TRS_IDLE && sync2 && $past(sync2)
        && $past(sync2, 2) && $past(sync2, 3) && !$past(sync2, 4) |-> valid)
        else $error("edge trigger missed");
    echo_rise_a: assert property (@(posedge clock) disable iff (!nrst)
        valid |=> echo)
        else $error("no echo for valid trigger");
    zr_range_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(zr) |-> range_start)
        else $error("range start not coincident");
    pass_amp_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.mode == trs_pkg::TRS_MODE_PASS |=> reply_amplitude_port == !$past(sync2))
        else $error("pass-through amplitude wrong");
    phase_sel_a: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> reply_phase_port == ($past(cfg.dual_gen) ? $past(reply_seq.amp2_n) : $past(reply_seq.phase)))
        else $error("phase output source wrong");
    amp_seq_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.mode != trs_pkg::TRS_MODE_PASS |=> reply_amplitude_port == $past(reply_seq.amp_n))
        else $error("amplitude sequence mismatch");

    edge_cov: cover property (@(posedge clock) disable iff (!nrst) cfg.mode == trs_pkg::TRS_MODE_EDGE && valid);
    pair_cov: cover property (@(posedge clock) disable iff (!nrst) cfg.mode == trs_pkg::TRS_MODE_PAIR && valid);
    pass_cov: cover property (@(posedge clock) disable iff (!nrst) cfg.mode == trs_pkg::TRS_MODE_PASS && $rose(echo));
    zr_cov: cover property (@(posedge clock) disable iff (!nrst) $rose(zero_range_marker_port));
endmodule : trs_ports
`default_nettype wire

// ---- dv/trs_trig_src.sv ----
// Trigger source model driving the trigger input
`default_nettype none
module trs_trig_src (
    // Clock
    input wire logic clock,
    // Trigger line
    output logic trig
);
    timeunit 1ns;
    timeprecision 100ps;
    initial trig = 1'b0;
    // High for w cycles, then low for gap cycles
    task automatic pulse(input int w, input int gap);
        @(negedge clock);
        trig = 1'b1;
        repeat (w) @(negedge clock);
        trig = 1'b0;
        repeat (gap) @(negedge clock);
    endtask : pulse
endmodule : trs_trig_src
`default_nettype wire

// ---- dv/test_trigger_reply_signal_ports.sv ----
// Bench for the trigger and reply signal ports block
`include "trs_params.svh"
`default_nettype none
module test_trigger_reply_signal_ports;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    trs_pkg::trs_cfg_t cfg = '0;
    trs_pkg::trs_reply_t rs = 3'h7;
    logic trig, rstart, echo, amp, ph, mark;
    logic echo_q = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    int n_hi, n_rise, n_mark, n_rs, n_amp;
    always #12.5 clock = ~clock;
    trs_ports dut (.clock(clock), .nrst(nrst), .cfg(cfg), .trigger_input_port(trig), .reply_seq(rs),
        .range_start(rstart), .trigger_echo_port(echo), .reply_amplitude_port(amp),
        .reply_phase_port(ph), .zero_range_marker_port(mark));
    trs_trig_src src (.clock(clock), .trig(trig));
    // Output event counters
    always @(posedge clock)
    begin
        echo_q <= echo;
        n_hi <= n_hi + int'(echo === 1'b1);
        n_rise <= n_rise + int'(echo === 1'b1 && echo_q === 1'b0);
        n_mark <= n_mark + int'(mark === 1'b1);
        n_rs <= n_rs + int'(rstart === 1'b1 && mark === 1'b1);
        n_amp <= n_amp + int'(amp === 1'b0);
    end
    task automatic clr();
        @(negedge clock);
        {n_hi, n_rise, n_mark, n_rs, n_amp} = '0;
    endtask : clr
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : check
    task automatic t_edge();
        cfg.echo_width = 16'h000A;
        cfg.reply_delay = 16'h0014;
        clr();
        src.pulse(8, 13334);
        src.pulse(8, 300);
        check(16'(n_rise), 16'h0002);
        check(16'(n_hi), 16'h0014);
        check(16'(n_mark), 16'h0002);
        check(16'(n_rs), 16'h0002);
        $display("edge trigger test done");
    endtask : t_edge
    task automatic t_short();
        for (int w = 3; w < 5; w++)
        begin
            clr();
            src.pulse(w, 300);
            check(16'(n_rise), 16'(w == 4));
            check(16'(n_mark), 16'(w == 4));
        end
        $display("short pulse test done");
    endtask : t_short
    task automatic t_clamp();
        for (int i = 0; i < 2; i++)
        begin
            cfg.echo_width = i ? 16'h00FA : 16'h0001;
            clr();
            src.pulse(8, 300);
            check(16'(n_hi), i ? 16'(`TRS_ECHO_MAX_CYC) : 16'(`TRS_ECHO_MIN_CYC));
        end
        $display("echo width test done");
    endtask : t_clamp
    task automatic t_pair();
        cfg.mode = trs_pkg::TRS_MODE_PAIR;
        cfg.pair_space = 16'h0014;
        cfg.pair_tol = 16'h0002;
        for (int i = 0; i < 2; i++)
        begin
            clr();
            src.pulse(6, i ? 34 : 14);
            src.pulse(6, 300);
            check(16'(n_rise), 16'(i == 0));
        end
        $display("pulse pair test done");
    endtask : t_pair
    task automatic t_pass();
        cfg.mode = trs_pkg::TRS_MODE_PASS;
        clr();
        src.pulse(10, 300);
        check(16'(n_amp), 16'h000A);
        check(16'(n_hi), 16'(`TRS_WINDOW_CYC));
        check(16'(n_rise), 16'h0001);
        check(16'(n_mark), 16'h0000);
        $display("pass-through test done");
    endtask : t_pass
    task automatic t_reply();
        cfg.mode = trs_pkg::TRS_MODE_EDGE;
        for (int i = 0; i < 4; i++)
        begin
            cfg.dual_gen = i[1];
            rs = {i[0], i[0], ~i[0]};
            repeat (3) @(negedge clock);
            check(16'(amp), 16'(i[0]));
            check(16'(ph), 16'(i[1] ? !i[0] : i[0]));
        end
        $display("reply output test done");
    endtask : t_reply
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (16) @(negedge clock);
        check(16'({echo, mark, rstart, amp, ph}), 16'h0003);
        nrst = 1'b1;
        t_edge();
        t_short();
        t_clamp();
        t_pair();
        t_pass();
        t_reply();
        tally_and_finish();
    end
    // Watchdog
    initial
    begin
        repeat (40000) @(negedge clock);
        n_fail++;
        tally_and_finish();
    end
endmodule : test_trigger_reply_signal_ports
`default_nettype wire
